// [include/hms_pkg.sv]
`default_nettype none
package hms_pkg;
  localparam int unsigned HMS_POS_W = 32;
  localparam int unsigned HMS_METHOD_W = 8;
  // offset from a z-less method to the method whose motion it reuses
  localparam logic [7:0] HMS_SWITCH_ORIGIN_OFS = 8'h10;
  localparam logic [7:0] HMS_M_NEG_LIMIT = 8'h01;
  localparam logic [7:0] HMS_M_POS_LIMIT = 8'h02;
  localparam logic [7:0] HMS_M_HOME_FIRST = 8'h03;
  localparam logic [7:0] HMS_M_HOME_LAST = 8'h0E;
  localparam logic [7:0] HMS_M_NEG_LIMIT_EDGE = 8'h11;
  localparam logic [7:0] HMS_M_POS_LIMIT_EDGE = 8'h12;
  localparam logic [7:0] HMS_M_HOME_EDGE_FIRST = 8'h13;
  localparam logic [7:0] HMS_M_HOME_EDGE_LAST = 8'h1E;
  localparam logic [7:0] HMS_M_INDEX_NEG = 8'h21;
  localparam logic [7:0] HMS_M_INDEX_POS = 8'h22;
  localparam logic [7:0] HMS_M_HOLD = 8'h23;
  localparam logic HMS_DIR_POS = 1'b1;
  localparam logic HMS_DIR_NEG = 1'b0;

  typedef enum logic [1:0] {
    SIG_HOME = 2'b00,
    SIG_NEG_LIMIT = 2'b01,
    SIG_POS_LIMIT = 2'b10
  } hms_sig_t;

  typedef enum logic [1:0] {
    KIND_SWITCH = 2'b00,
    KIND_INDEX = 2'b01,
    KIND_HOLD = 2'b10
  } hms_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEARCH = 3'b010,
    ST_INDEX = 3'b100
  } hms_st_t;

  typedef struct packed {
    logic home;
    logic negLimit;
    logic posLimit;
    logic index;
  } hms_sw_t;

  typedef struct packed {
    logic enable;
    logic positive;
    logic fast;
  } hms_move_t;

  typedef struct packed {
    logic valid;
    hms_kind_t kind;
    hms_sig_t sigSel;
    logic dirOff;
    logic dirOn;
    logic tgtRise;
    logic tgtDir;
    logic useIndex;
    logic limAlarm;
  } hms_cfg_t;

  typedef struct packed {
    hms_st_t st;
    hms_cfg_t cfg;
    logic dir;
    logic fast;
    hms_sw_t prevSw;
    logic [HMS_POS_W-1:0] originPos;
    logic originValid;
    logic donePulse;
    logic alarm;
    logic refused;
  } hms_regs_t;
endpackage : hms_pkg
`default_nettype wire

// [rtl/hms_sequencer.sv]
// Function
// - methods 5,6: start opposite home, fall edge
// - methods 7,8: start positive if home off
// - methods 9,10: always start positive
// - methods 11,12: start negative if home off
// - methods 13,14: always start negative
// - methods 17,18: origin at limit rising edge
// - methods 19-30: origin at home slow edge
// - methods 33,34: first index pulse, no switch
// - method 35: origin is current position
// - method 1, limit off: fast negative, reverse
// - method 1, limit on: slow positive start
// - method 2, limit off: fast positive, reverse
// - method 2, limit on: slow negative start
// - methods 3-6,19-22: limit stops with alarm
// - method 3: fall edge moving negative
// - method 4: rise edge moving positive
`default_nettype none
module hms_sequencer (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [hms_pkg::HMS_METHOD_W-1:0] method,
  input wire hms_pkg::hms_sw_t sw,
  input wire logic [hms_pkg::HMS_POS_W-1:0] position,
  output hms_pkg::hms_move_t move,
  output logic busy,
  output logic homingDone,
  output logic originValid,
  output logic [hms_pkg::HMS_POS_W-1:0] originPosition,
  output logic alarm,
  output logic refused
);
  import hms_pkg::*;

  // dirOff/dirOn: start direction with selected signal off/on
  function automatic hms_cfg_t homeCfg(
    input logic dOff,
    input logic dOn,
    input logic rise,
    input logic tDir,
    input logic z,
    input logic lim
  );
    hms_cfg_t c;
    c.valid = 1'b1;
    c.kind = KIND_SWITCH;
    c.sigSel = SIG_HOME;
    c.dirOff = dOff;
    c.dirOn = dOn;
    c.tgtRise = rise;
    c.tgtDir = tDir;
    c.useIndex = z;
    c.limAlarm = lim;
    return c;
  endfunction : homeCfg

  function automatic hms_cfg_t methodCfg(input logic [HMS_METHOD_W-1:0] m);
    hms_cfg_t c;
    logic [HMS_METHOD_W-1:0] b;
    logic z;
    c = '0;
    z = 1'b1;
    b = m;
    if (m >= HMS_M_HOME_EDGE_FIRST && m <= HMS_M_HOME_EDGE_LAST) begin
      b = m - HMS_SWITCH_ORIGIN_OFS;
      z = 1'b0;
    end
    case (b)
      8'h03: begin
        c = homeCfg(HMS_DIR_POS, HMS_DIR_NEG, 1'b0, HMS_DIR_NEG, z, 1'b1);
      end
      8'h04: begin
        c = homeCfg(HMS_DIR_POS, HMS_DIR_NEG, 1'b1, HMS_DIR_POS, z, 1'b1);
      end
      8'h05: begin
        c = homeCfg(HMS_DIR_NEG, HMS_DIR_POS, 1'b0, HMS_DIR_POS, z, 1'b1);
      end
      8'h06: begin
        c = homeCfg(HMS_DIR_NEG, HMS_DIR_POS, 1'b0, HMS_DIR_NEG, z, 1'b1);
      end
      8'h07: begin
        c = homeCfg(HMS_DIR_POS, HMS_DIR_NEG, 1'b0, HMS_DIR_NEG, z, 1'b0);
      end
      8'h08: begin
        c = homeCfg(HMS_DIR_POS, HMS_DIR_NEG, 1'b1, HMS_DIR_POS, z, 1'b0);
      end
      8'h09: begin
        c = homeCfg(HMS_DIR_POS, HMS_DIR_POS, 1'b1, HMS_DIR_NEG, z, 1'b0);
      end
      8'h0A: begin
        c = homeCfg(HMS_DIR_POS, HMS_DIR_POS, 1'b0, HMS_DIR_POS, z, 1'b0);
      end
      8'h0B: begin
        c = homeCfg(HMS_DIR_NEG, HMS_DIR_POS, 1'b0, HMS_DIR_POS, z, 1'b0);
      end
      8'h0C: begin
        c = homeCfg(HMS_DIR_NEG, HMS_DIR_POS, 1'b1, HMS_DIR_NEG, z, 1'b0);
      end
      8'h0D: begin
        c = homeCfg(HMS_DIR_NEG, HMS_DIR_NEG, 1'b1, HMS_DIR_POS, z, 1'b0);
      end
      8'h0E: begin
        c = homeCfg(HMS_DIR_NEG, HMS_DIR_NEG, 1'b0, HMS_DIR_NEG, z, 1'b0);
      end
      8'h01: begin
        c = homeCfg(HMS_DIR_NEG, HMS_DIR_POS, 1'b0, HMS_DIR_POS, 1'b1, 1'b1);
        c.sigSel = SIG_NEG_LIMIT;
      end
      8'h02: begin
        c = homeCfg(HMS_DIR_POS, HMS_DIR_NEG, 1'b0, HMS_DIR_NEG, 1'b1, 1'b1);
        c.sigSel = SIG_POS_LIMIT;
      end
      8'h11: begin
        c = homeCfg(HMS_DIR_NEG, HMS_DIR_POS, 1'b1, HMS_DIR_NEG, 1'b0, 1'b1);
        c.sigSel = SIG_NEG_LIMIT;
      end
      8'h12: begin
        c = homeCfg(HMS_DIR_POS, HMS_DIR_NEG, 1'b1, HMS_DIR_POS, 1'b0, 1'b1);
        c.sigSel = SIG_POS_LIMIT;
      end
      8'h21: begin
        c.valid = 1'b1;
        c.kind = KIND_INDEX;
        c.tgtDir = HMS_DIR_NEG;
      end
      8'h22: begin
        c.valid = 1'b1;
        c.kind = KIND_INDEX;
        c.tgtDir = HMS_DIR_POS;
      end
      8'h23: begin
        c.valid = 1'b1;
        c.kind = KIND_HOLD;
      end
      default: begin
        c = '0;
      end
    endcase
    return c;
  endfunction : methodCfg

  function automatic logic pickSig(input hms_sw_t s, input hms_sig_t sel);
    logic v;
    v = s.home;
    if (sel == SIG_NEG_LIMIT) begin
      v = s.negLimit;
    end else if (sel == SIG_POS_LIMIT) begin
      v = s.posLimit;
    end
    return v;
  endfunction : pickSig

  hms_regs_t s_q;
  hms_regs_t s_d;
  hms_cfg_t newCfg;
  logic [3:0] swRise;
  logic [3:0] swFall;
  logic sigRise;
  logic sigFall;
  logic tgtEdge;
  logic revEdge;
  logic fwdLimit;
  logic limitIsSig;
  logic idxRise;
  logic startDir;

  // per-input edges against last cycle's sample
  for (genvar g = 0; g < 4; g++) begin : gEdge
    assign swRise[g] = sw[g] & ~s_q.prevSw[g];
    assign swFall[g] = ~sw[g] & s_q.prevSw[g];
  end

  always_comb begin
    s_d = s_q;
    s_d.donePulse = 1'b0;
    s_d.refused = 1'b0;
    s_d.prevSw = sw;
    newCfg = methodCfg(method);
    sigRise = pickSig(hms_sw_t'(swRise), s_q.cfg.sigSel);
    sigFall = pickSig(hms_sw_t'(swFall), s_q.cfg.sigSel);
    tgtEdge = s_q.cfg.tgtRise ? sigRise : sigFall;
    revEdge = s_q.cfg.tgtRise ? sigFall : sigRise;
    fwdLimit = s_q.dir ? sw.posLimit : sw.negLimit;
    limitIsSig = (s_q.cfg.sigSel == SIG_NEG_LIMIT && s_q.dir == HMS_DIR_NEG) ||
                 (s_q.cfg.sigSel == SIG_POS_LIMIT && s_q.dir == HMS_DIR_POS);
    idxRise = swRise[0];
    startDir = pickSig(sw, newCfg.sigSel) ? newCfg.dirOn : newCfg.dirOff;
    case (s_q.st)
      ST_IDLE: begin
        if (start) begin
          if (!newCfg.valid) begin
            s_d.refused = 1'b1;
          end else begin
            s_d.cfg = newCfg;
            s_d.alarm = 1'b0;
            s_d.originValid = 1'b0;
            if (newCfg.kind == KIND_HOLD) begin
              s_d.originPos = position;
              s_d.originValid = 1'b1;
              s_d.donePulse = 1'b1;
            end else if (newCfg.kind == KIND_INDEX) begin
              s_d.st = ST_INDEX;
              s_d.dir = newCfg.tgtDir;
              s_d.fast = 1'b0;
            end else begin
              s_d.st = ST_SEARCH;
              s_d.dir = startDir;
              s_d.fast = (startDir != newCfg.tgtDir);
              // limit-edge methods run fast toward the limit
              if (newCfg.sigSel != SIG_HOME && !newCfg.useIndex &&
                  !pickSig(sw, newCfg.sigSel)) begin
                s_d.fast = 1'b1;
              end
            end
          end
        end
      end
      ST_SEARCH: begin
        if (sigRise | sigFall) begin
          s_d.fast = 1'b0;
        end
        if (s_q.dir == s_q.cfg.tgtDir && tgtEdge) begin
          if (s_q.cfg.useIndex) begin
            s_d.st = ST_INDEX;
            s_d.fast = 1'b0;
          end else begin
            s_d.originPos = position;
            s_d.originValid = 1'b1;
            s_d.donePulse = 1'b1;
            s_d.st = ST_IDLE;
          end
        end else if (s_q.dir != s_q.cfg.tgtDir && revEdge) begin
          s_d.dir = s_q.cfg.tgtDir;
          s_d.fast = 1'b0;
        end else if (fwdLimit && !limitIsSig) begin
          if (s_q.cfg.limAlarm) begin
            s_d.alarm = 1'b1;
            s_d.st = ST_IDLE;
          end else begin
            s_d.dir = ~s_q.dir;
          end
        end
      end
      ST_INDEX: begin
        if (idxRise) begin
          s_d.originPos = position;
          s_d.originValid = 1'b1;
          s_d.donePulse = 1'b1;
          s_d.st = ST_IDLE;
        end else if (fwdLimit) begin
          s_d.alarm = 1'b1;
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = (s_q.st != ST_IDLE);
  assign move.enable = busy;
  assign move.positive = s_q.dir;
  assign move.fast = s_q.fast;
  assign homingDone = s_q.donePulse;
  assign originValid = s_q.originValid;
  assign originPosition = s_q.originPos;
  assign alarm = s_q.alarm;
  assign refused = s_q.refused;
endmodule : hms_sequencer
`default_nettype wire

// [test/hms_sequencer_chk.sv]
`default_nettype none
module hms_sequencer_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [hms_pkg::HMS_METHOD_W-1:0] method,
  input wire logic [hms_pkg::HMS_POS_W-1:0] position,
  input wire hms_pkg::hms_move_t move,
  input wire logic busy,
  input wire logic homingDone,
  input wire logic originValid,
  input wire logic [hms_pkg::HMS_POS_W-1:0] originPosition,
  input wire logic alarm,
  input wire logic refused
);
  import hms_pkg::*;
  wire logic taken = start && !busy;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  a_alarm_stop: assert property (alarm |-> !busy && !move.enable)
    else $error("alarm while moving");
  a_done_valid: assert property (homingDone |-> originValid && !busy)
    else $error("done without origin");
  a_hold_origin: assert property (taken && method == HMS_M_HOLD
    |=> homingDone && !busy && originPosition == $past(position)) else $error("hold origin");
  a_index_neg: assert property (taken && method == HMS_M_INDEX_NEG
    |=> busy && move.positive == HMS_DIR_NEG && !move.fast) else $error("index search");
  a_always_pos: assert property (taken && method inside {8'h09, 8'h0A}
    |=> move.positive == HMS_DIR_POS) else $error("start not positive");
  a_always_neg: assert property (taken && method inside {8'h0D, 8'h0E}
    |=> move.positive == HMS_DIR_NEG) else $error("start not negative");
  a_refuse_code: assert property (taken && method inside {8'h0F, 8'h10, 8'h1F, 8'h20}
    |=> refused && !busy) else $error("reserved accepted");
  a_refuse_keep: assert property (refused |-> originValid == $past(originValid))
    else $error("origin changed");
endmodule : hms_sequencer_chk

bind hms_sequencer hms_sequencer_chk u_hms_sequencer_chk (.*);
`default_nettype wire

// [test/hms_axis_model.sv]
`default_nettype none
module hms_axis_model (
  input wire logic clk,
  input wire logic load,
  input wire logic [hms_pkg::HMS_POS_W-1:0] loadPos,
  input wire hms_pkg::hms_move_t move,
  output hms_pkg::hms_sw_t sw,
  output logic [hms_pkg::HMS_POS_W-1:0] position
);
  import hms_pkg::*;
  logic signed [HMS_POS_W-1:0] posQ;
  assign position = posQ;
  always_ff @(posedge clk) begin
    if (load) begin
      posQ <= loadPos;
    end else if (move.enable) begin
      posQ <= move.positive ? posQ + (move.fast ? 4 : 1) : posQ - (move.fast ? 4 : 1);
    end
  end
  // home active below 100, limits at -200 and 300, index every 16 counts
  assign sw = {posQ < 100, posQ <= -200, posQ >= 300, posQ[3:0] == 4'h0};
endmodule : hms_axis_model
`default_nettype wire

// [test/tb.sv]
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import hms_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  logic load = 1'b1;
  logic [7:0] method = 8'h00;
  logic [31:0] loadPos = 32'h0000_0028;
  logic [31:0] position;
  logic [31:0] originPosition;
  hms_sw_t sw;
  hms_move_t move;
  logic busy, homingDone, originValid, alarm, refused, dir0, fast0;
  int bad_count = 0;
  int n_tests = 0;
  int cycles = 0;
  hms_sequencer u_hms_sequencer (.*);
  hms_axis_model u_hms_axis_model (.*);
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : check
  task automatic home(input logic [7:0] m, input logic [31:0] p, input int n);
    @(negedge clk);
    load = 1'b1;
    loadPos = p;
    @(negedge clk);
    load = 1'b0;
    start = 1'b1;
    method = m;
    @(negedge clk);
    start = 1'b0;
    dir0 = move.positive;
    fast0 = move.fast;
    for (int i = 0; i < n && (homingDone | alarm | refused) !== 1'b1; i++) begin
      @(negedge clk);
    end
  endtask : home
  task automatic t_index;
    home(HMS_M_INDEX_NEG, 32'h0000_0028, 3000);
    check({dir0, homingDone, originPosition}, {2'b01, 32'h0000_0020});
    home(HMS_M_INDEX_POS, 32'h0000_0028, 3000);
    check({dir0, homingDone, originPosition}, {2'b11, 32'h0000_0030});
    home(HMS_M_HOLD, 32'h0000_0028, 3);
    check({homingDone, busy, originPosition}, {2'b10, 32'h0000_0028});
  endtask : t_index
  task automatic t_reserved;
    logic [7:0] codes [6] = '{8'h00, 8'h0F, 8'h10, 8'h1F, 8'h20, 8'h24};
    foreach (codes[i]) begin
      home(codes[i], 32'h0000_0050, 3);
      check({refused, originValid, originPosition}, {2'b11, 32'h0000_0028});
    end
  endtask : t_reserved
  task automatic t_limits;
    home(HMS_M_NEG_LIMIT, 32'h0000_0028, 3000);
    check({dir0, fast0, homingDone, originPosition}, {3'b011, 32'hFFFF_FF40});
    home(HMS_M_NEG_LIMIT, 32'hFFFF_FF30, 3000);
    check({dir0, fast0, homingDone, originPosition}, {3'b101, 32'hFFFF_FF40});
    home(HMS_M_POS_LIMIT, 32'h0000_0028, 3000);
    check({dir0, fast0, homingDone, originPosition}, {3'b111, 32'h0000_0120});
    home(HMS_M_POS_LIMIT, 32'h0000_0130, 3000);
    check({dir0, fast0, homingDone, originPosition}, {3'b001, 32'h0000_0120});
    home(HMS_M_NEG_LIMIT_EDGE, 32'h0000_0028, 3000);
    check({fast0, homingDone, originPosition}, {2'b11, 32'hFFFF_FF38});
    home(HMS_M_POS_LIMIT_EDGE, 32'h0000_0028, 3000);
    check({fast0, homingDone, originPosition}, {2'b11, 32'h0000_012C});
  endtask : t_limits
  task automatic t_home;
    home(8'h05, 32'h0000_00C8, 3000);
    check({dir0, fast0, homingDone, originPosition}, {3'b011, 32'h0000_0070});
    home(8'h15, 32'h0000_00C8, 3000);
    check({homingDone, originPosition}, {1'b1, 32'h0000_0064});
    home(HMS_M_HOME_FIRST, 32'h0000_00C8, 3000);
    check({dir0, alarm, busy, originValid}, 4'b1100);
  endtask : t_home
  task automatic t_dirs;
    for (int m = 3; m <= 14; m++) begin
      for (int on = 0; on < 2; on++) begin
        home(8'(m), on ? 32'h0000_0028 : 32'h0000_00C8, 0);
        check(dir0, on ? m inside {5, 6, [9:12]} : m inside {3, 4, [7:10]});
        @(negedge clk);
        reset = 1'b1;
        @(negedge clk);
        reset = 1'b0;
      end
    end
  endtask : t_dirs
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (16) @(negedge clk);
    reset = 1'b0;
    load = 1'b0;
    t_index();
    t_reserved();
    t_limits();
    t_home();
    t_dirs();
    end_sim();
  end
endmodule : tb
`default_nettype wire
